// File: design/sdis_pkg.sv
package sdis_pkg;

	// ************************************************
	// Timing
	// ************************************************
	localparam int CLK_PERIOD_PS    = 8000;
	localparam int POWERUP_WAIT_US  = 200;
	localparam int POWERUP_CYC      =
		(POWERUP_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ROW_ACTIVE_NS    = 42;
	localparam int ROW_ACTIVE_CYC   =
		(ROW_ACTIVE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SETUP_PS         = 1500;
	localparam int ROW_CYCLE_NS     = 63;
	localparam int ROW_CYCLE_CYC    =
		(ROW_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PRECHARGE_NS     = 21;
	localparam int PRECHARGE_CYC    =
		(PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int EXIT_WAIT_CYC    =
		(SETUP_PS + ROW_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int MODE_WAIT_CYC    = 2;
	localparam int INIT_REFRESHES   = 2;
	localparam int BURST_REFRESHES  = 4096;
	localparam int RESTART_CYC      = 8;

	// ************************************************
	// Commands {cs_n, ras_n, cas_n, we_n}
	// ************************************************
	localparam logic [3:0] CMD_NOP      = 4'h7;
	localparam logic [3:0] CMD_DESELECT = 4'hF;
	localparam logic [3:0] CMD_PRECHG   = 4'h2;
	localparam logic [3:0] CMD_REFRESH  = 4'h1;
	localparam logic [3:0] CMD_MODE_SET = 4'h0;

	localparam logic [11:0] MODE_DEFAULT = 12'h020;

	typedef enum logic [3:0] {
		ST_POWERUP   = 4'h0,
		ST_PRECHARGE = 4'h1,
		ST_TRP       = 4'h2,
		ST_MODE      = 4'h3,
		ST_TMRD      = 4'h4,
		ST_REFRESH   = 4'h5,
		ST_TRC       = 4'h6,
		ST_READY     = 4'h7,
		ST_SR_ENTER  = 4'h8,
		ST_SR_DWELL  = 4'h9,
		ST_SR_HOLD   = 4'hA,
		ST_SR_CLKON  = 4'hB,
		ST_SR_EXIT   = 4'hC
	} sdis_state_type;

endpackage

// File: design/sdis_ctrl.sv
`timescale 1ns/1ps
// Contract
// - Power-up: clock enable low, mask high, NOP
// - Stable clock 200 us before enable
// - Keep mask high during initialization
// - Precharge all four banks after enable
// - Load mode register before normal use
// - At least two init auto-refreshes
// - Refreshes before or after mode load
// - Self-refresh entry: CS RAS CAS CKE low
// - Inputs ignored one cycle after entry
// - Dwell at least row-active time
// - Row-active dwell is 42 ns
// - Exit: restart clock, CKE high, deselect
// - Wait exit interval before real commands
// - Exit interval is setup plus row cycle
// - Burst refresh 4096 before and after
module sdis_ctrl #(
	parameter int BURST_N    = sdis_pkg::BURST_REFRESHES,
	parameter int POWERUP_N  = sdis_pkg::POWERUP_CYC,
	parameter bit BURST_MODE = 1'b1,
	parameter int INIT_REF_N = sdis_pkg::INIT_REFRESHES
) (
	// Clock and reset
	input  wire logic        CLOCK_I,
	input  wire logic        NRST_I,
	// User side
	input  wire logic        SR_ENTER_I,
	input  wire logic        SR_EXIT_I,
	output logic             READY_O,
	output logic             IN_SELF_REFRESH_O,
	// Memory pins
	output logic             MEM_CLK_EN_O,
	output logic             MEM_CLK_RUN_O,
	output logic             MEM_CS_N_O,
	output logic             MEM_RAS_N_O,
	output logic             MEM_CAS_N_O,
	output logic             MEM_WE_N_O,
	output logic             MEM_DQM_O,
	output logic [1:0]       MEM_BA_O,
	output logic [11:0]      MEM_ADDR_O
);

	// Counters are 20 bits wide; larger counts would wrap silently
	if (POWERUP_N < 1 || BURST_N < 1 || INIT_REF_N < 2 ||
	    POWERUP_N >= 2**20 || BURST_N >= 2**20 ||
	    INIT_REF_N >= 2**20) begin : g_bad_params
		$error("sdis_ctrl: unsupported parameter values");
	end

	// ************************************************
	// State
	// ************************************************
	sdis_pkg::sdis_state_type state_r, state_nxt;
	logic [19:0] wait_r, wait_nxt;
	logic [19:0] ref_r, ref_nxt;
	logic        post_exit_r, post_exit_nxt;
	logic [3:0]  cmd_nxt;
	logic        cke_nxt, clk_run_nxt, ready_nxt, insr_nxt;
	logic [11:0] addr_nxt;

	wire wait_done = (wait_r == 20'h00000);
	wire [19:0] burst_last = 20'(BURST_MODE ? BURST_N - 1 : 0);
	wire [19:0] init_last  = 20'(INIT_REF_N - 1);
	wire ref_done_init  = (ref_r == init_last);
	wire ref_done_burst = (ref_r == burst_last);

	always_comb begin
		state_nxt     = state_r;
		wait_nxt      = wait_done ? wait_r : wait_r - 20'h00001;
		ref_nxt       = ref_r;
		post_exit_nxt = post_exit_r;
		cmd_nxt       = sdis_pkg::CMD_NOP;
		cke_nxt       = 1'b1;
		clk_run_nxt   = 1'b1;
		ready_nxt     = 1'b0;
		insr_nxt      = 1'b0;
		addr_nxt      = 12'h000;
		unique case (state_r)
		sdis_pkg::ST_POWERUP: begin
			cke_nxt = 1'b0;
			if (wait_done) begin
				state_nxt = sdis_pkg::ST_PRECHARGE;
			end
		end
		sdis_pkg::ST_PRECHARGE: begin
			cmd_nxt  = sdis_pkg::CMD_PRECHG;
			addr_nxt = 12'h400;
			wait_nxt = 20'(sdis_pkg::PRECHARGE_CYC);
			state_nxt = sdis_pkg::ST_TRP;
		end
		sdis_pkg::ST_TRP: begin
			if (wait_done) begin
				state_nxt = sdis_pkg::ST_MODE;
			end
		end
		sdis_pkg::ST_MODE: begin
			// Mode first, refreshes after; either order is legal
			cmd_nxt  = sdis_pkg::CMD_MODE_SET;
			addr_nxt = sdis_pkg::MODE_DEFAULT;
			wait_nxt = 20'(sdis_pkg::MODE_WAIT_CYC);
			ref_nxt  = 20'h00000;
			state_nxt = sdis_pkg::ST_TMRD;
		end
		sdis_pkg::ST_TMRD: begin
			if (wait_done) begin
				state_nxt = sdis_pkg::ST_REFRESH;
			end
		end
		sdis_pkg::ST_REFRESH: begin
			cmd_nxt  = sdis_pkg::CMD_REFRESH;
			wait_nxt = 20'(sdis_pkg::ROW_CYCLE_CYC);
			state_nxt = sdis_pkg::ST_TRC;
		end
		sdis_pkg::ST_TRC: begin
			if (wait_done) begin
				ref_nxt = ref_r + 20'h00001;
				if (post_exit_r ? ref_done_burst : ref_done_init) begin
					post_exit_nxt = 1'b0;
					ref_nxt   = 20'h00000;
					state_nxt = sdis_pkg::ST_READY;
				end else begin
					state_nxt = sdis_pkg::ST_REFRESH;
				end
			end
		end
		sdis_pkg::ST_READY: begin
			ready_nxt = ~SR_ENTER_I;
			if (SR_ENTER_I) begin
				// Pre-entry burst reuses the refresh counter
				ref_nxt   = ref_r + 20'h00001;
				cmd_nxt   = sdis_pkg::CMD_REFRESH;
				wait_nxt  = 20'(sdis_pkg::ROW_CYCLE_CYC);
				state_nxt = sdis_pkg::ST_SR_ENTER;
				if (!BURST_MODE) begin
					wait_nxt = 20'h00000;
					cmd_nxt  = sdis_pkg::CMD_NOP;
				end
			end
		end
		sdis_pkg::ST_SR_ENTER: begin
			if (wait_done) begin
				if (ref_r <= burst_last && BURST_MODE &&
				    ref_r != 20'(BURST_N)) begin
					ref_nxt  = ref_r + 20'h00001;
					cmd_nxt  = sdis_pkg::CMD_REFRESH;
					wait_nxt = 20'(sdis_pkg::ROW_CYCLE_CYC);
				end else begin
					cmd_nxt  = sdis_pkg::CMD_REFRESH;
					cke_nxt  = 1'b0;
					wait_nxt = 20'(sdis_pkg::ROW_ACTIVE_CYC);
					ref_nxt  = 20'h00000;
					state_nxt = sdis_pkg::ST_SR_DWELL;
				end
			end
		end
		sdis_pkg::ST_SR_DWELL: begin
			cke_nxt  = 1'b0;
			insr_nxt = 1'b1;
			if (wait_done) begin
				state_nxt = sdis_pkg::ST_SR_HOLD;
			end
		end
		sdis_pkg::ST_SR_HOLD: begin
			// Clock may stop now; only clock enable matters
			cke_nxt     = 1'b0;
			clk_run_nxt = 1'b0;
			insr_nxt    = 1'b1;
			if (SR_EXIT_I) begin
				wait_nxt  = 20'(sdis_pkg::RESTART_CYC);
				state_nxt = sdis_pkg::ST_SR_CLKON;
			end
		end
		sdis_pkg::ST_SR_CLKON: begin
			cke_nxt  = 1'b0;
			insr_nxt = 1'b1;
			cmd_nxt  = sdis_pkg::CMD_DESELECT;
			if (wait_done) begin
				wait_nxt  = 20'(sdis_pkg::EXIT_WAIT_CYC);
				state_nxt = sdis_pkg::ST_SR_EXIT;
			end
		end
		sdis_pkg::ST_SR_EXIT: begin
			cmd_nxt = sdis_pkg::CMD_DESELECT;
			if (wait_done) begin
				post_exit_nxt = 1'b1;
				ref_nxt   = 20'h00000;
				state_nxt = BURST_MODE ? sdis_pkg::ST_REFRESH
				                       : sdis_pkg::ST_READY;
			end
		end
		default: begin
			state_nxt = sdis_pkg::ST_POWERUP;
			cke_nxt   = 1'b0;
		end
		endcase
	end

	// ************************************************
	// Registers
	// ************************************************
	always_ff @(posedge CLOCK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			state_r     <= sdis_pkg::ST_POWERUP;
			wait_r      <= 20'(POWERUP_N);
			ref_r       <= 20'h00000;
			post_exit_r <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			wait_r      <= wait_nxt;
			ref_r       <= ref_nxt;
			post_exit_r <= post_exit_nxt;
		end
	end

	// Outputs registered so pins change only on clock edges or on async reset assertion
	always_ff @(posedge CLOCK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			MEM_CLK_EN_O      <= 1'b0;
			MEM_CLK_RUN_O     <= 1'b1;
			{MEM_CS_N_O, MEM_RAS_N_O, MEM_CAS_N_O, MEM_WE_N_O} <=
				sdis_pkg::CMD_NOP;
			MEM_DQM_O         <= 1'b1;
			MEM_BA_O          <= 2'h0;
			MEM_ADDR_O        <= 12'h000;
			READY_O           <= 1'b0;
			IN_SELF_REFRESH_O <= 1'b0;
		end else begin
			MEM_CLK_EN_O      <= cke_nxt;
			MEM_CLK_RUN_O     <= clk_run_nxt;
			{MEM_CS_N_O, MEM_RAS_N_O, MEM_CAS_N_O, MEM_WE_N_O} <= cmd_nxt;
			MEM_DQM_O         <= 1'b1;
			MEM_BA_O          <= 2'h0;
			MEM_ADDR_O        <= addr_nxt;
			READY_O           <= ready_nxt;
			IN_SELF_REFRESH_O <= insr_nxt;
		end
	end

endmodule

// File: bench/sdis_mem_model.sv
`timescale 1ns/1ps
module sdis_mem_model (
	// Clock and pins
	input  wire logic        clk_i,
	input  wire logic        cke_i,
	input  wire logic [3:0]  cmd_i,
	input  wire logic        a10_i,
	// Observed state
	output logic             sr_o,
	output logic             pre_o,
	output logic             mode_o,
	output logic [15:0]      refs_o
);
	logic cke_q = 1'b0;
	initial begin
		sr_o   = 1'b0;
		pre_o  = 1'b0;
		mode_o = 1'b0;
		refs_o = 16'h0000;
	end
	// No reset pin on the device: state lives from power-up
	always @(posedge clk_i) begin
		cke_q <= cke_i;
		if (sr_o) begin
			if (cke_i) sr_o <= 1'b0;
		end else if (cke_q && !cke_i && cmd_i == 4'h1) begin
			sr_o <= 1'b1;
		end else if (cke_i) begin
			if (cmd_i == 4'h2 && a10_i) pre_o <= 1'b1;
			if (cmd_i == 4'h0) mode_o <= 1'b1;
			if (cmd_i == 4'h1) refs_o <= refs_o + 16'h0001;
		end
	end
endmodule

// File: bench/sdis_chk_sva.sv
`timescale 1ns/1ps
module sdis_chk #(
	parameter int POWERUP_N = sdis_pkg::POWERUP_CYC
) (
	input wire logic        CLOCK_I,
	input wire logic        NRST_I,
	input wire logic        READY_O,
	input wire logic        IN_SELF_REFRESH_O,
	input wire logic        MEM_CLK_EN_O,
	input wire logic        MEM_CLK_RUN_O,
	input wire logic        MEM_CS_N_O,
	input wire logic        MEM_RAS_N_O,
	input wire logic        MEM_CAS_N_O,
	input wire logic        MEM_WE_N_O,
	input wire logic        MEM_DQM_O,
	input wire logic [11:0] MEM_ADDR_O
);
	logic [3:0]  cmd;
	int unsigned up_r;
	logic [3:0]  refs_r;
	assign cmd = {MEM_CS_N_O, MEM_RAS_N_O, MEM_CAS_N_O, MEM_WE_N_O};
	always_ff @(posedge CLOCK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			up_r   <= 0;
			refs_r <= 4'h0;
		end else begin
			if (up_r < POWERUP_N) up_r <= up_r + 1;
			if (READY_O) refs_r <= 4'h0;
			// Saturate so long bursts cannot wrap to a small count
			else if (cmd == 4'h1 && MEM_CLK_EN_O && refs_r != 4'hF)
				refs_r <= refs_r + 4'h1;
		end
	end
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!NRST_I);
	sequence s_prech;
		cmd == 4'h2 && MEM_CLK_EN_O && MEM_ADDR_O[10];
	endsequence
	sequence s_mode_load;
		(cmd == 4'h7)[*4] ##1 (cmd == 4'h0 && MEM_ADDR_O == 12'h020);
	endsequence
	sequence s_exit_wait;
		MEM_CS_N_O [*8] ##1 MEM_CS_N_O;
	endsequence
	chk_mask_high: assert property (MEM_DQM_O)
		else $error("mask pin dropped");
	chk_pwr_wait: assert property (up_r < POWERUP_N |->
		!MEM_CLK_EN_O && cmd == 4'h7) else $error("early clock enable");
	chk_first_prech: assert property (
		$rose(MEM_CLK_EN_O) && !$past(IN_SELF_REFRESH_O) |-> s_prech)
		else $error("no precharge-all at enable");
	chk_mode_order: assert property (s_prech |=> s_mode_load)
		else $error("mode load not after precharge");
	chk_init_refs: assert property ($rose(READY_O) |-> refs_r >= 4'h2)
		else $error("too few refreshes");
	chk_entry_cmd: assert property ($fell(MEM_CLK_EN_O) |-> cmd == 4'h1)
		else $error("bad entry command");
	chk_sr_dwell: assert property (
		$fell(MEM_CLK_EN_O) |=> !MEM_CLK_EN_O [*6]) else $error("dwell short");
	chk_exit_desel: assert property (
		$rose(MEM_CLK_EN_O) && $past(IN_SELF_REFRESH_O) |-> s_exit_wait)
		else $error("command too soon after exit");
	chk_clk_stop: assert property (
		!MEM_CLK_RUN_O |-> !MEM_CLK_EN_O && IN_SELF_REFRESH_O)
		else $error("clock stopped outside self-refresh");
	chk_clk_settle: assert property (
		$rose(MEM_CLK_RUN_O) |-> !MEM_CLK_EN_O [*8])
		else $error("clock enable before clock settled");
endmodule
bind sdis_ctrl sdis_chk #(.POWERUP_N(POWERUP_N)) u_chk (
	.CLOCK_I(CLOCK_I), .NRST_I(NRST_I), .READY_O(READY_O),
	.IN_SELF_REFRESH_O(IN_SELF_REFRESH_O), .MEM_CLK_EN_O(MEM_CLK_EN_O),
	.MEM_CLK_RUN_O(MEM_CLK_RUN_O),
	.MEM_CS_N_O(MEM_CS_N_O), .MEM_RAS_N_O(MEM_RAS_N_O),
	.MEM_CAS_N_O(MEM_CAS_N_O), .MEM_WE_N_O(MEM_WE_N_O),
	.MEM_DQM_O(MEM_DQM_O), .MEM_ADDR_O(MEM_ADDR_O)
);

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam int PWR_N = 20;
	localparam int BST_N = 3;
	localparam int LIM   = 400;
	logic        clk, nrst, sr_enter, sr_exit, ready, in_sr, cke;
	logic        cs_n, ras_n, cas_n, we_n, dqm, m_sr, m_pre, m_mode;
	logic        clk_run;
	logic [1:0]  ba;
	logic [11:0] addr;
	logic [15:0] m_refs;
	int          miscompares = 0;
	int          cmp_count   = 0;
	sdis_ctrl #(.BURST_N(BST_N), .POWERUP_N(PWR_N)) dut (
		.CLOCK_I(clk), .NRST_I(nrst), .SR_ENTER_I(sr_enter),
		.SR_EXIT_I(sr_exit), .READY_O(ready), .IN_SELF_REFRESH_O(in_sr),
		.MEM_CLK_EN_O(cke), .MEM_CLK_RUN_O(clk_run), .MEM_CS_N_O(cs_n),
		.MEM_RAS_N_O(ras_n), .MEM_CAS_N_O(cas_n), .MEM_WE_N_O(we_n),
		.MEM_DQM_O(dqm), .MEM_BA_O(ba), .MEM_ADDR_O(addr)
	);
	sdis_mem_model mdl (
		.clk_i(clk), .cke_i(cke), .cmd_i({cs_n, ras_n, cas_n, we_n}),
		.a10_i(addr[10]), .sr_o(m_sr), .pre_o(m_pre), .mode_o(m_mode),
		.refs_o(m_refs)
	);
	task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic tmo(int n);
		if (n >= LIM) begin
			miscompares++;
			wrap_up();
		end
	endtask
	task automatic t_init();
		int n;
		nrst = 1'b0;
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		for (n = 0; n < LIM && !cke; n++) @(negedge clk);
		tmo(n);
		cmp("powerup_wait", 1, n >= PWR_N);
		for (n = 0; n < LIM && !ready; n++) @(negedge clk);
		tmo(n);
		@(negedge clk);
		cmp("prech_all", 1, m_pre);
		cmp("mode_load", 1, m_mode);
		cmp("init_refs", 2, m_refs);
		cmp("mask_high", 1, dqm);
		cmp("bank_zero", 0, ba);
	endtask
	// Exit is asked for at once, so the dwell refusal is exercised
	task automatic t_sr();
		int n;
		logic [15:0] r0;
		logic        stopped;
		r0 = m_refs;
		sr_enter = 1'b1;
		sr_exit = 1'b1;
		for (n = 0; n < LIM && !in_sr; n++) @(negedge clk);
		tmo(n);
		sr_enter = 1'b0;
		@(negedge clk);
		cmp("burst_before", BST_N, m_refs - r0);
		cmp("entered", 1, m_sr);
		cmp("ready_low", 0, ready);
		stopped = 1'b0;
		for (n = 0; n < LIM && in_sr; n++) begin
			stopped = stopped | !clk_run;
			@(negedge clk);
		end
		tmo(n);
		sr_exit = 1'b0;
		cmp("clock_stop", 1, stopped);
		cmp("dwell", 1, n >= sdis_pkg::ROW_ACTIVE_CYC);
		r0 = m_refs;
		for (n = 0; n < LIM && !ready; n++) @(negedge clk);
		tmo(n);
		@(negedge clk);
		cmp("burst_after", BST_N, m_refs - r0);
		cmp("exited", 0, m_sr);
		cmp("clock_run", 1, clk_run);
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		nrst = 1'b0;
		sr_enter = 1'b0;
		sr_exit = 1'b0;
		t_init();
		t_sr();
		t_sr();
		wrap_up();
	end
endmodule
